// >>> core/pin_sync.sv
// module: two-flop synchroniser with a third stage for edge detection
`timescale 1ns/1ps
module pin_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic pin,
    output logic      level,
    output logic      rise
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } sync_s;

    sync_s st_q;
    sync_s st_d;

    // first stage feeds only the second; edges come from stages two and three
    always_comb begin
        st_d    = st_q;
        st_d.s1 = pin;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{s1: RESET_VAL, s2: RESET_VAL, s3: RESET_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign level = st_q.s2;
    assign rise  = st_q.s2 & ~st_q.s3;
endmodule : pin_sync

// >>> core/reset_halt_mode_sequencer.sv
// module: reset state, reset sequence, halt and run mode control
// Overview of operation
// - power detection forces reset state
// - both pins low holds reset state
// - reset pin rising edge enters reset
// - run bit 0-to-1 resets when pin high
// - first eight cycles always reset
// - reset state followed by call 0, nop
// - halt issues nops; parallel DMA continues
// - powerup end both low: stay reset
// - powerup end reset high: sequence, run
// - float high, reset low: sequence, halt
// - reset low or bit 0 halts run
// - reset pin beats run bit
// - leaving halt goes via reset, sequence
// - both low resets now, as powerup
// - reassert within ten cycles halts immediately
// - float over eight cycles tristates outputs
`timescale 1ns/1ps
module reset_halt_mode_sequencer (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              reset_input_low_n,
    input  wire logic              float_request_low_n,
    input  wire logic              run_bit,
    output logic                   core_reset,
    output rst_seq_pkg::ins_e      inject_ins,
    output logic [23:0]            call_target,
    output logic [3:0]             call_link_reg,
    output logic                   fetch_enable,
    output logic                   halted,
    output logic                   dma_enable,
    output logic                   outputs_float
);
    import rst_seq_pkg::*;

    logic rst_lvl;
    logic rst_rise;
    logic flt_lvl;

    // -------------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------------
    pin_sync #(.RESET_VAL(1'b0)) u_sync_rst (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .pin     (reset_input_low_n),
        .level   (rst_lvl),
        .rise    (rst_rise)
    );

    pin_sync #(.RESET_VAL(1'b0)) u_sync_flt (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .pin     (float_request_low_n),
        .level   (flt_lvl),
        .rise    ()
    );

    typedef struct packed {
        mode_e      mode;
        logic [3:0] pu_cnt;
        logic [3:0] flt_cnt;
        logic [3:0] win_cnt;
        logic       win_act;
        logic       halt_next;
        logic       run_prev;
        logic       core_reset;
        ins_e       ins;
        logic       fetch;
        logic       halted;
        logic       flt_out;
        logic       dma;
    } seq_s;

    seq_s st_q;
    seq_s st_d;
    logic both_low;
    logic bit_rise;
    logic go_reset;

    // -------------------------------------------------------------------
    // sequencer
    // -------------------------------------------------------------------
    assign both_low = ~rst_lvl & ~flt_lvl;
    assign bit_rise = run_bit & ~st_q.run_prev;
    // pin edge, or run bit edge only while the pin is released
    assign go_reset = rst_rise | (bit_rise & rst_lvl);

    always_comb begin
        st_d          = st_q;
        st_d.run_prev = run_bit;
        // float-out counter saturates at the limit
        if (flt_lvl) begin
            st_d.flt_cnt = CNT_RESET;
        end else if (st_q.flt_cnt != FLOAT_LIMIT) begin
            st_d.flt_cnt = st_q.flt_cnt + 4'h1;
        end
        st_d.flt_out = (st_d.flt_cnt == FLOAT_LIMIT);
        // halt window opened by the pin releasing a reset
        if (st_q.win_act) begin
            st_d.win_cnt = st_q.win_cnt + 4'h1;
            if (st_q.win_cnt == HALT_WIN_LAST) begin
                st_d.win_act = 1'b0;
            end
        end
        if (st_q.win_act && !rst_lvl) begin
            st_d.halt_next = 1'b1;
            st_d.win_act   = 1'b0;
        end
        unique case (st_q.mode)
            ST_POWERUP: begin
                st_d.pu_cnt = st_q.pu_cnt + 4'h1;
                if (st_q.pu_cnt == POWERUP_LAST) begin
                    if (both_low) begin
                        st_d.mode = ST_RESET;
                    end else begin
                        st_d.halt_next = ~rst_lvl;
                        st_d.mode      = ST_SEQ_CALL;
                    end
                end
            end
            ST_RESET: begin
                // held while both pins low; leaves as from powerup
                if (!both_low) begin
                    st_d.halt_next = ~rst_lvl;
                    st_d.mode      = ST_SEQ_CALL;
                end
            end
            ST_SEQ_CALL: begin
                st_d.mode = ST_SEQ_NOP;
                if (rst_rise) begin
                    st_d.win_act = 1'b1;
                    st_d.win_cnt = CNT_RESET;
                end
            end
            ST_SEQ_NOP: begin
                // nops go on while the halt window is open, so a quick
                // reassert halts before any fetched instruction runs
                if (st_q.halt_next || !rst_lvl) begin
                    st_d.mode      = ST_HALT;
                    st_d.halt_next = 1'b0;
                    st_d.win_act   = 1'b0;
                end else if (!st_q.win_act) begin
                    st_d.mode      = ST_RUN;
                    st_d.halt_next = 1'b0;
                end
            end
            ST_RUN: begin
                // pin low wins over the bit; bit low also halts
                if (!rst_lvl || !run_bit) begin
                    st_d.mode = ST_HALT;
                end
            end
            ST_HALT: begin
                if (go_reset) begin
                    st_d.mode      = ST_SEQ_CALL;
                    st_d.halt_next = 1'b0;
                    st_d.win_act   = rst_rise;
                    st_d.win_cnt   = CNT_RESET;
                end
            end
        endcase
        // both pins low reset at once from anywhere after powerup
        if (st_q.mode != ST_POWERUP && both_low) begin
            st_d.mode    = ST_RESET;
            st_d.win_act = 1'b0;
        end else if (st_q.mode == ST_RUN && go_reset) begin
            st_d.mode    = ST_SEQ_CALL;
            st_d.win_act = rst_rise;
            st_d.win_cnt = CNT_RESET;
        end
        // registered outputs decoded from the next mode
        st_d.core_reset = (st_d.mode == ST_POWERUP) || (st_d.mode == ST_RESET) || (st_d.mode == ST_SEQ_CALL
                          && st_q.mode != ST_SEQ_CALL);
        st_d.ins    = (st_d.mode == ST_SEQ_CALL) ? INS_CALL :
                      ((st_d.mode == ST_SEQ_NOP) || (st_d.mode == ST_HALT)) ? INS_NOP : INS_NONE;
        st_d.fetch  = (st_d.mode == ST_RUN);
        st_d.halted = (st_d.mode == ST_HALT);
        st_d.dma    = ~st_d.core_reset; // dma kept alive in halt
    end

    // power detection is the asynchronous reset itself
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{mode: ST_POWERUP, pu_cnt: CNT_RESET, flt_cnt: CNT_RESET, win_cnt: CNT_RESET,
                      win_act: 1'b0, halt_next: 1'b0, run_prev: RUN_BIT_RESET, core_reset: 1'b1,
                      ins: INS_NONE, fetch: 1'b0, halted: 1'b0, flt_out: 1'b0, dma: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign core_reset    = st_q.core_reset;
    assign inject_ins    = st_q.ins;
    assign call_target   = CALL_TARGET;
    assign call_link_reg = LINK_REG;
    assign fetch_enable  = st_q.fetch;
    assign halted        = st_q.halted;
    assign dma_enable    = st_q.dma;
    assign outputs_float = st_q.flt_out;

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    sequence s_pu_hold;
        core_reset [*8];
    endsequence

    property p_pu;
        @(posedge ref_clk) $rose(rst_n) |-> s_pu_hold;
    endproperty
    a_pu: assert property (p_pu) else $error("powerup reset shorter than eight cycles");

    property p_both_low;
        @(posedge ref_clk) disable iff (!rst_n) both_low |=> core_reset;
    endproperty
    a_both_low: assert property (p_both_low) else $error("both pins low without reset");

    sequence s_seq;
        inject_ins == INS_CALL ##1 inject_ins == INS_NOP;
    endsequence

    property p_seq;
        @(posedge ref_clk) disable iff (!rst_n) $rose(inject_ins == INS_CALL) |-> s_seq;
    endproperty
    a_seq: assert property (p_seq) else $error("call not followed by nop");

    property p_halt_nop;
        @(posedge ref_clk) disable iff (!rst_n) halted |-> (inject_ins == INS_NOP && !fetch_enable && dma_enable);
    endproperty
    a_halt_nop: assert property (p_halt_nop) else $error("halt not issuing nops");

    property p_rise;
        @(posedge ref_clk) disable iff (!rst_n)
            ((fetch_enable || halted) && rst_rise && !both_low) |=> (core_reset && inject_ins == INS_CALL);
    endproperty
    a_rise: assert property (p_rise) else $error("pin rise did not reset");

    property p_run_halt;
        @(posedge ref_clk) disable iff (!rst_n)
            (fetch_enable && !rst_lvl && !both_low) |=> halted;
    endproperty
    a_run_halt: assert property (p_run_halt) else $error("pin low did not halt");

    property p_float;
        @(posedge ref_clk) disable iff (!rst_n) (!flt_lvl) [*8] ##1 !flt_lvl |=> outputs_float;
    endproperty
    a_float: assert property (p_float) else $error("float not tristating");

    property p_no_fetch_seq;
        @(posedge ref_clk) disable iff (!rst_n) (inject_ins != INS_NONE) |-> !fetch_enable;
    endproperty
    a_no_fetch_seq: assert property (p_no_fetch_seq) else $error("fetch during injected code");
endmodule : reset_halt_mode_sequencer

// >>> core/rst_seq_pkg.sv
// package: constants, states and timing for the reset/halt sequencer
package rst_seq_pkg;
    // power-on interval, in input clock cycles
    localparam int unsigned POWERUP_CYCLES = 8;
    localparam logic [3:0]  POWERUP_LAST   = 4'h7;
    // float request held longer than this many periods tristates outputs
    localparam int unsigned FLOAT_CYCLES   = 8;
    localparam logic [3:0]  FLOAT_LIMIT    = 4'h8;
    // window after a pin-released reset in which reassertion halts at once
    localparam int unsigned HALT_WIN_CYCLES = 10;
    localparam logic [3:0]  HALT_WIN_LAST   = 4'h9;
    // reset sequence: call target and link register
    localparam logic [23:0] CALL_TARGET    = 24'h000000;
    localparam logic [3:0]  LINK_REG       = 4'he;
    // values after reset
    localparam logic [3:0]  CNT_RESET      = 4'h0;
    localparam logic        RUN_BIT_RESET  = 1'b0;

    typedef enum logic [2:0] {
        ST_POWERUP,
        ST_RESET,
        ST_SEQ_CALL,
        ST_SEQ_NOP,
        ST_RUN,
        ST_HALT
    } mode_e;

    typedef enum logic [1:0] {
        INS_NONE,
        INS_CALL,
        INS_NOP
    } ins_e;
endpackage : rst_seq_pkg

// >>> sim/ext_pins.sv
// partner model: system logic driving the reset and float request pins
`timescale 1ns/1ps
module ext_pins (
    input  wire logic ref_clk,
    output logic      reset_input_low_n,
    output logic      float_request_low_n
);
    // both pins are always driven by the system logic, never left floating
    initial begin
        reset_input_low_n   = 1'b0;
        float_request_low_n = 1'b1;
    end

    // pins move after a falling edge, well clear of the sampling edge
    task automatic drive(input logic rst_lvl, input logic flt_lvl);
        @(negedge ref_clk);
        reset_input_low_n   = rst_lvl;
        float_request_low_n = flt_lvl;
    endtask : drive

    // release the reset pin, then pull it low again after gap cycles
    task automatic rise_fall(input int gap);
        drive(1'b1, 1'b1);
        repeat (gap) @(negedge ref_clk);
        reset_input_low_n = 1'b0;
    endtask : rise_fall
endmodule : ext_pins

// >>> sim/testbench.sv
// testbench: mode model and checks for the reset/halt sequencer
`timescale 1ns/1ps
module testbench;
    import rst_seq_pkg::*;
    logic        ref_clk, rst_n, run_bit, core_reset, fetch_enable;
    logic        halted, dma_enable, outputs_float;
    logic        reset_input_low_n, float_request_low_n;
    ins_e        inject_ins, prev_ins;
    logic [23:0] call_target;
    logic [3:0]  call_link_reg;
    logic [31:0] rng;
    int          fails, checks, n_call, n_nop, n_fetch, flt_cnt, exp_mode, gap, nf;

    ext_pins pins (.ref_clk(ref_clk), .reset_input_low_n(reset_input_low_n),
                   .float_request_low_n(float_request_low_n));
    reset_halt_mode_sequencer uut (.ref_clk(ref_clk), .rst_n(rst_n), .reset_input_low_n(reset_input_low_n),
        .float_request_low_n(float_request_low_n), .run_bit(run_bit), .core_reset(core_reset),
        .inject_ins(inject_ins), .call_target(call_target), .call_link_reg(call_link_reg),
        .fetch_enable(fetch_enable), .halted(halted), .dma_enable(dma_enable), .outputs_float(outputs_float));

    // ----------------------------------------
    // clock, monitor and compare tasks
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // counts sampled mid-cycle, so registered outputs are settled
    always @(negedge ref_clk) begin
        flt_cnt  <= (!rst_n || float_request_low_n) ? 0 : flt_cnt + 1;
        prev_ins <= inject_ins;
        if (rst_n && inject_ins === INS_CALL) begin
            n_call <= n_call + 1;
            chk_val({call_link_reg, call_target}, {4'h0, LINK_REG, CALL_TARGET});
        end
        if (rst_n && inject_ins === INS_NOP && prev_ins === INS_CALL) n_nop <= n_nop + 1;
        if (fetch_enable === 1'b1) n_fetch <= n_fetch + 1;
    end

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: value %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    // 0 reset, 1 run, 2 halt; halt keeps injecting nops with dma alive
    task automatic chk_mode(input int m);
        chk_val({core_reset, fetch_enable, halted, dma_enable}, {m == 0, m == 1, m == 2, m != 0});
        chk_val(32'(inject_ins), (m == 2) ? 32'(INS_NOP) : 32'(INS_NONE));
        chk_val(32'(outputs_float), 32'(flt_cnt > FLOAT_CYCLES));
    endtask : chk_mode

    // model: next settled mode from old mode, old and new pin and bit levels
    function automatic int predict(int m, logic pr, logic r, logic f, logic pb, logic b);
        if (!r && !f) return 0;
        if (m == 0) return r ? 1 : 2;
        if (!r) return 2;
        if (m == 2) return (!pr || (b && !pb)) ? 1 : 2;
        return b ? 1 : 2;
    endfunction : predict

    task automatic step(input logic r, input logic f, input logic b);
        int m, c, n, s;
        m = predict(exp_mode, reset_input_low_n, r, f, run_bit, b);
        c = n_call;
        n = n_nop;
        pins.drive(r, f);
        run_bit = b;
        repeat (20) @(negedge ref_clk);
        s = int'((m == 1 && exp_mode != 1) || (exp_mode == 0 && m == 2));
        exp_mode = m;
        chk_mode(m);
        chk_val(n_call - c, s);
        chk_val(n_nop - n, s);
        $display("step done, mode %0d", m);
    endtask : step

    // power-up with given pin levels; reset holds for the whole interval
    task automatic pu(input logic r, input logic f);
        int c;
        pins.drive(r, f);
        rst_n   = 1'b0;
        run_bit = 1'b1;
        c = n_call;
        repeat (2) @(negedge ref_clk);
        chk_val(32'(core_reset), 32'h1);
        rst_n = 1'b1;
        repeat (POWERUP_CYCLES - 1) begin
            @(negedge ref_clk);
            chk_val(32'(core_reset), 32'h1);
        end
        repeat (20) @(negedge ref_clk);
        exp_mode = r ? 1 : (f ? 2 : 0);
        chk_mode(exp_mode);
        chk_val(n_call - c, 32'(exp_mode != 0));
        $display("powerup done, mode %0d", exp_mode);
    endtask : pu

    task automatic results;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        run_bit = 1'b0;
        rng = 32'ha020;
        {fails, checks, n_call, n_nop, n_fetch, flt_cnt} = '0;
        prev_ins = INS_NONE;
        pu(1'b0, 1'b0);
        step(1'b0, 1'b1, 1'b1);
        pu(1'b0, 1'b1);
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        pu(1'b1, rng[0]);
        step(1'b1, 1'b1, 1'b0);
        step(1'b1, 1'b1, 1'b1);
        step(1'b0, 1'b1, 1'b1);
        step(1'b1, 1'b1, 1'b1);
        step(1'b0, 1'b0, 1'b1);
        step(1'b1, 1'b1, 1'b1);
        step(1'b0, 1'b1, 1'b1);
        step(1'b0, 1'b1, 1'b0);
        step(1'b0, 1'b1, 1'b1);
        // quick reassert must halt with no fetch at all
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        gap = 1 + int'(rng[7:0] % 6);
        nf = n_fetch;
        pins.rise_fall(gap);
        repeat (20) @(negedge ref_clk);
        chk_mode(2);
        chk_val(n_fetch - nf, 32'h0);
        $display("quick reassert done, gap %0d", gap);
        results();
    end

    // cuts a hang short
    initial begin
        #200us;
        fails++;
        results();
    end
endmodule : testbench
